// ===== lbs_pkg.sv
package lbs_pkg;

	// Region width codes
	localparam logic [1:0] WIDTH_8  = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;
	localparam logic [1:0] WIDTH_32 = 2'h2;

	// Long bursts stop at this aligned boundary
	localparam logic [31:0] DMA_BOUNDARY = 32'h0000_0800;

	// Core bursts never carry more data transfers than this
	localparam logic [31:0] CORE_MAX_BEATS = 32'h0000_0004;

	// Active-low byte lane patterns
	localparam logic [3:0] BE_ALL  = 4'h0;
	localparam logic [3:0] BE_NONE = 4'hf;

	// Length code driven for DMA bursts
	localparam logic [1:0] SIZE_DMA = 2'h0;

	// Internal ready timing and staging memory
	localparam int INT_WAIT_DEFAULT  = 0;
	localparam int INT_WAIT_MAX      = 15;
	localparam int MEM_WORDS_DEFAULT = 1024;
	localparam logic [3:0] WAIT_CNT_RESET = 4'h0;

	// Bus states
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_PREP    = 3'b001,
		ST_ADDR    = 3'b010,
		ST_DATA    = 3'b011,
		ST_RECOVER = 3'b100
	} lbs_state_t;

	// One access request from the core or a block mover
	typedef struct packed {
		logic        write;
		logic        dma;
		logic [1:0]  width;
		logic        internal;
		logic [31:0] addr;
		logic [11:0] nbytes;
	} lbs_req_t;

	// Bus pins driven by the sequencer
	typedef struct packed {
		logic        address_strobe_n;
		logic        final_transfer_n;
		logic [3:0]  byte_lane_enable_n;
		logic        write;
		logic        ad_oe;
		logic [31:0] ad;
	} lbs_bus_t;

	localparam lbs_req_t REQ_RESET = '0;
	localparam lbs_bus_t BUS_RESET = '{
		address_strobe_n:   1'b1,
		final_transfer_n:   1'b1,
		byte_lane_enable_n: 4'hf,
		write:              1'b0,
		ad_oe:              1'b0,
		ad:                 32'h0000_0000
	};

endpackage

// ===== lbs_word_mem.sv
module lbs_word_mem
	import lbs_pkg::*;
#(
	parameter int WORDS = MEM_WORDS_DEFAULT,
	parameter int AW    = $clog2(MEM_WORDS_DEFAULT)
) (
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          rst,
	// Requester port
	input  wire logic          user_we,
	input  wire logic [3:0]    user_be,
	input  wire logic [AW-1:0] user_addr,
	input  wire logic [31:0]   user_wdata,
	output logic [31:0]        user_rdata,
	// Sequencer port
	input  wire logic          seq_re,
	input  wire logic [AW-1:0] seq_raddr,
	output logic [31:0]        seq_rdata,
	input  wire logic          seq_we,
	input  wire logic [AW-1:0] seq_waddr,
	input  wire logic [3:0]    seq_be,
	input  wire logic [31:0]   seq_wdata
);

	logic [31:0] mem [WORDS];

	// Byte writes; the sequencer wins a same-byte collision
	always_ff @(posedge clock) begin
		for (int i = 0; i < 4; i++) begin
			if (user_we && user_be[i])
				mem[user_addr][8*i +: 8] <= user_wdata[8*i +: 8];
			if (seq_we && seq_be[i])
				mem[seq_waddr][8*i +: 8] <= seq_wdata[8*i +: 8];
		end
	end

	// Registered reads; sequencer data holds until the next enable
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			user_rdata <= 32'h0000_0000;
			seq_rdata  <= 32'h0000_0000;
		end else begin
			user_rdata <= mem[user_addr];
			if (seq_re)
				seq_rdata <= mem[seq_raddr];
		end
	end

endmodule

// ===== lbs_sequencer.sv
// How it works
// - Short word: 8-bit two-byte burst, wider single access; odd offset two bytes.
// - 8-bit words: four-byte bursts; offsets 1 and 2 add edge pieces.
// - 8-bit offset 3: byte, one four-byte burst, two-byte burst, byte.
// - 16-bit aligned words: bursts of up to four short words.
// - 16-bit unaligned words: byte/short edges around two-short bursts.
// - 32-bit aligned: bursts of up to four words; unaligned: edges plus singles.
// - 32-bit nonzero word offset: n separate single-word accesses.
// - Block mover bursts run until the next aligned 2K boundary.
// - Length code on low muxed lines is meaningless for block mover bursts.
// - Every transaction opens with address strobe and closes with final transfer.
// - Block mover bursts stay unsplit, byte lanes vary per transfer.
// - Core bursts drive all four byte lane enables low.
// - Ready/recover is synchronous and controls every wait state type.
// - After address, ready low completes; high adds an address-to-data wait.
// - Bursts sample ready every edge; high adds data-to-data wait.
// - Internal controller regions get ready generated inside the block.
// - Core bursts hold at most four data transfers.
// - One recovery state; extra ones while ready/recover is low.
module lbs_sequencer
	import lbs_pkg::*;
#(
	parameter int MEM_WORDS = MEM_WORDS_DEFAULT,
	parameter int INT_WAIT  = INT_WAIT_DEFAULT
) (
	// Clock and reset
	input  wire logic                         clock,
	input  wire logic                         rst,
	// Request
	input  wire lbs_req_t                     req,
	input  wire logic                         req_valid,
	output logic                              req_ready,
	output logic                              done,
	// Staging memory port
	input  wire logic                         user_we,
	input  wire logic [3:0]                   user_be,
	input  wire logic [$clog2(MEM_WORDS)-1:0] user_addr,
	input  wire logic [31:0]                  user_wdata,
	output logic [31:0]                       user_rdata,
	// Local bus
	output lbs_bus_t                          local_bus,
	input  wire logic [31:0]                  ad_in,
	input  wire logic                         external_ready_recover_n
);

	localparam int AW = $clog2(MEM_WORDS);

	// Refuse shapes the logic cannot serve
	if (MEM_WORDS < 2 || (MEM_WORDS & (MEM_WORDS - 1)) != 0) begin : g_chk_mem
		$error("MEM_WORDS must be a power of two, at least 2");
	end
	if (INT_WAIT < 0 || INT_WAIT > INT_WAIT_MAX) begin : g_chk_wait
		$error("INT_WAIT out of range");
	end

	localparam logic [3:0] INT_WAIT_CNT = 4'(INT_WAIT);

	lbs_state_t   st_q, st_d;
	lbs_req_t     req_q, req_d;
	lbs_bus_t     bus_q, bus_d;
	logic [31:0]  cur_q, cur_d, fin_q, fin_d, base_q, base_d, pend_q, pend_d;
	logic         aligned_q, aligned_d, burst_q, burst_d;
	logic         ready_q, ready_d, done_q, done_d;
	logic [3:0]   wcnt_q, wcnt_d;
	logic         mem_re, mem_we;
	logic [AW-1:0] mem_raddr, mem_waddr;
	logic [3:0]   mem_be;
	logic [31:0]  mem_rdata, mem_wdata;
	logic [31:0]  bn, n2, np, nfirst;
	logic         first_burst, ready_n, int_ready_n;
	lbs_bus_t     addr_bus;

	function automatic logic [31:0] bus_bytes(input logic [1:0] w);
		if (w == WIDTH_8)
			return 32'h1;
		else if (w == WIDTH_16)
			return 32'h2;
		else
			return 32'h4;
	endfunction

	function automatic logic [31:0] min32(input logic [31:0] a, b);
		return (a < b) ? a : b;
	endfunction

	// End of the bus-wide chunk holding a, cut at the piece end
	function automatic logic [31:0] beat_end(input logic [1:0] w,
			input logic [31:0] a, input logic [31:0] pend);
		logic [31:0] bb;
		bb = bus_bytes(w);
		return min32((a & ~(bb - 32'h1)) + bb, pend);
	endfunction

	// End of the next access, from width, offset and mode
	function automatic logic [31:0] piece_end(input logic [1:0] w,
			input logic [31:0] cur, input logic [31:0] fin,
			input logic dma, input logic aligned);
		logic [31:0] rem;
		logic [31:0] unit;
		rem = fin - cur;
		if (cur[1:0] == 2'b00 && rem >= 32'h4)
			unit = 32'h4;
		else if (!cur[0] && rem >= 32'h2)
			unit = 32'h2;
		else
			unit = 32'h1;
		if (dma)
			return min32(fin, (cur & ~(DMA_BOUNDARY - 32'h1)) + DMA_BOUNDARY);
		else if (aligned)
			return min32(fin, cur + bus_bytes(w) * CORE_MAX_BEATS);
		else
			return cur + unit;
	endfunction

	function automatic logic [31:0] beat_count(input logic [1:0] w,
			input logic [31:0] a, input logic [31:0] pend);
		int sh;
		sh = (w == WIDTH_8) ? 0 : (w == WIDTH_16) ? 1 : 2;
		return ((pend - 32'h1) >> sh) - (a >> sh) + 32'h1;
	endfunction

	// Narrow regions carry their data on the low lanes
	function automatic logic [31:0] lane_out(input logic [1:0] w,
			input logic [31:0] a, input logic [31:0] word);
		if (w == WIDTH_8)
			return {24'h0, word[8*a[1:0] +: 8]};
		else if (w == WIDTH_16)
			return {16'h0, a[1] ? word[31:16] : word[15:0]};
		else
			return word;
	endfunction

	function automatic logic [31:0] lane_in(input logic [1:0] w,
			input logic [31:0] d);
		if (w == WIDTH_8)
			return {4{d[7:0]}};
		else if (w == WIDTH_16)
			return {2{d[15:0]}};
		else
			return d;
	endfunction

	function automatic logic [3:0] lane_mask(input logic [31:0] a,
			input logic [31:0] n);
		logic [3:0] m;
		m = (n == 32'h1) ? 4'h1 : (n == 32'h2) ? 4'h3 :
			(n == 32'h3) ? 4'h7 : 4'hf;
		return 4'(m << a[1:0]);
	endfunction

	// Byte enables per beat, using the narrow-bus alternate meanings
	function automatic logic [3:0] be_enc(input logic [1:0] w,
			input logic [31:0] a, input logic [31:0] n, input logic burst);
		logic lo;
		logic hi;
		lo = !a[0];
		hi = a[0] || n > 32'h1;
		if (burst)
			return BE_ALL;
		else if (w == WIDTH_8)
			return {2'b11, a[1:0]};
		else if (w == WIDTH_16)
			return {!hi, 1'b1, a[1], !lo};
		else
			return ~lane_mask(a, n);
	endfunction

	function automatic logic [AW-1:0] widx(input logic [31:0] a,
			input logic [31:0] base);
		logic [31:0] d;
		d = (a - base) >> 2;
		return d[AW-1:0];
	endfunction

	// Natural boundary mask of a core request
	function automatic logic [31:0] nat_mask(input logic [11:0] nbytes);
		if (nbytes == 12'h1)
			return 32'h0;
		else if (nbytes == 12'h2)
			return 32'h1;
		else if (nbytes == 12'h4)
			return 32'h3;
		else if (nbytes == 12'h8)
			return 32'h7;
		else
			return 32'hf;
	endfunction

	lbs_word_mem #(
		.WORDS (MEM_WORDS),
		.AW    (AW)
	) u_mem (
		.clock      (clock),
		.rst        (rst),
		.user_we    (user_we),
		.user_be    (user_be),
		.user_addr  (user_addr),
		.user_wdata (user_wdata),
		.user_rdata (user_rdata),
		.seq_re     (mem_re),
		.seq_raddr  (mem_raddr),
		.seq_rdata  (mem_rdata),
		.seq_we     (mem_we),
		.seq_waddr  (mem_waddr),
		.seq_be     (mem_be),
		.seq_wdata  (mem_wdata)
	);

	// Ready source: counted locally for controller regions
	assign int_ready_n = !(st_q == ST_DATA && wcnt_q >= INT_WAIT_CNT);
	assign ready_n = req_q.internal ? int_ready_n
		: external_ready_recover_n;

	// Next piece and its address-state pin values
	always_comb begin
		bn = beat_end(req_q.width, cur_q, pend_q);
		n2 = beat_end(req_q.width, bn, pend_q);
		np = piece_end(req_q.width, cur_q, fin_q, req_q.dma, aligned_q);
		nfirst = beat_end(req_q.width, cur_q, np);
		first_burst = !req_q.dma && beat_count(req_q.width, cur_q, np) > 32'h1;
		addr_bus = bus_q;
		addr_bus.address_strobe_n = 1'b0;
		addr_bus.final_transfer_n = 1'b1;
		addr_bus.byte_lane_enable_n = be_enc(req_q.width, cur_q,
			nfirst - cur_q, first_burst);
		addr_bus.write = req_q.write;
		addr_bus.ad_oe = 1'b1;
		// Length code only means something for core pieces
		addr_bus.ad = {cur_q[31:2], req_q.dma ? SIZE_DMA
			: 2'(beat_count(req_q.width, cur_q, np) - 32'h1)};
	end

	// Bus state machine
	always_comb begin
		st_d = st_q;
		req_d = req_q;
		bus_d = bus_q;
		cur_d = cur_q;
		fin_d = fin_q;
		base_d = base_q;
		pend_d = pend_q;
		aligned_d = aligned_q;
		burst_d = burst_q;
		ready_d = 1'b0;
		done_d = 1'b0;
		wcnt_d = wcnt_q;
		mem_re = 1'b0;
		mem_raddr = widx(cur_q, base_q);
		mem_we = 1'b0;
		mem_waddr = widx(cur_q, base_q);
		mem_be = lane_mask(cur_q, bn - cur_q);
		mem_wdata = lane_in(req_q.width, ad_in);
		unique case (st_q)
			ST_IDLE: begin
				ready_d = 1'b1;
				bus_d.byte_lane_enable_n = BE_NONE;
				if (req_valid && ready_q) begin
					ready_d = 1'b0;
					req_d = req;
					cur_d = req.addr;
					fin_d = req.addr + 32'(req.nbytes);
					base_d = {req.addr[31:2], 2'b00};
					// Offset within the natural boundary picks the pattern
					aligned_d = (req.addr & nat_mask(req.nbytes)) == 32'h0;
					st_d = ST_PREP;
				end
			end
			// One quiet cycle so the first write word is fetched
			ST_PREP: begin
				mem_re = 1'b1;
				st_d = ST_ADDR;
				pend_d = np;
				burst_d = first_burst;
				bus_d = addr_bus;
			end
			ST_ADDR: begin
				mem_re = 1'b1;
				mem_raddr = widx(bn, base_q);
				st_d = ST_DATA;
				wcnt_d = WAIT_CNT_RESET;
				bus_d.address_strobe_n = 1'b1;
				bus_d.final_transfer_n = (bn == pend_q) ? 1'b0 : 1'b1;
				bus_d.byte_lane_enable_n = be_enc(req_q.width, cur_q,
					bn - cur_q, burst_q);
				bus_d.ad_oe = req_q.write;
				if (req_q.write)
					bus_d.ad = lane_out(req_q.width, cur_q, mem_rdata);
			end
			ST_DATA: begin
				if (ready_n) begin
					// High: address-to-data or data-to-data wait
					wcnt_d = wcnt_q + 4'h1;
				end else begin
					wcnt_d = WAIT_CNT_RESET;
					mem_we = !req_q.write;
					cur_d = bn;
					if (bn == pend_q) begin
						st_d = ST_RECOVER;
						bus_d.final_transfer_n = 1'b1;
						bus_d.byte_lane_enable_n = BE_NONE;
					end else begin
						// Next transfer of the burst; its word is already read
						mem_re = 1'b1;
						mem_raddr = widx(n2, base_q);
						bus_d.final_transfer_n = (n2 == pend_q) ? 1'b0 : 1'b1;
						bus_d.byte_lane_enable_n = be_enc(req_q.width, bn,
							n2 - bn, burst_q);
						if (req_q.write)
							bus_d.ad = lane_out(req_q.width, bn, mem_rdata);
					end
				end
			end
			ST_RECOVER: begin
				// Prefetch the next piece's first word while turning round
				mem_re = 1'b1;
				if (!ready_n) begin
					st_d = ST_RECOVER;
				end else if (cur_q == fin_q) begin
					st_d = ST_IDLE;
					done_d = 1'b1;
				end else begin
					st_d = ST_ADDR;
					pend_d = np;
					burst_d = first_burst;
					bus_d = addr_bus;
				end
			end
			default: begin
				st_d = ST_IDLE;
				bus_d = BUS_RESET;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q      <= ST_IDLE;
			req_q     <= REQ_RESET;
			bus_q     <= BUS_RESET;
			cur_q     <= 32'h0000_0000;
			fin_q     <= 32'h0000_0000;
			base_q    <= 32'h0000_0000;
			pend_q    <= 32'h0000_0000;
			aligned_q <= 1'b0;
			burst_q   <= 1'b0;
			ready_q   <= 1'b0;
			done_q    <= 1'b0;
			wcnt_q    <= WAIT_CNT_RESET;
		end else begin
			st_q      <= st_d;
			req_q     <= req_d;
			bus_q     <= bus_d;
			cur_q     <= cur_d;
			fin_q     <= fin_d;
			base_q    <= base_d;
			pend_q    <= pend_d;
			aligned_q <= aligned_d;
			burst_q   <= burst_d;
			ready_q   <= ready_d;
			done_q    <= done_d;
			wcnt_q    <= wcnt_d;
		end
	end

	assign req_ready = ready_q;
	assign done      = done_q;
	assign local_bus = bus_q;

endmodule

// ===== lbs_monitor.sv
module lbs_monitor
	import lbs_pkg::*;
(
	// Clock and reset
	input wire logic     clock,
	input wire logic     rst,
	// Request side
	input wire lbs_req_t req,
	input wire logic     req_valid,
	input wire logic     req_ready,
	input wire logic     done,
	// Bus side
	input wire lbs_bus_t local_bus,
	input wire logic     external_ready_recover_n
);
	// Short names; ready only counts for external regions
	wire logic as_n = local_bus.address_strobe_n;
	wire logic fin  = local_bus.final_transfer_n;
	wire logic rdy  = external_ready_recover_n;
	wire logic ext  = !req.internal;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	strobe_pulse_a: assert property (!as_n |=> as_n)
		else $error("address strobe longer than one cycle");
	addr_state_a: assert property (!as_n |-> fin && local_bus.ad_oe)
		else $error("address state without address drive");
	wait_holds_a: assert property (!fin && rdy && ext |=>
		!fin && $stable(local_bus.byte_lane_enable_n))
		else $error("last transfer ended while ready high");
	last_done_a: assert property (!fin && !rdy && ext |=>
		fin && local_bus.byte_lane_enable_n == BE_NONE)
		else $error("no recovery after last transfer");
	extra_recover_a: assert property ((!fin && !rdy && ext) ##1 !rdy
		|=> as_n && !done)
		else $error("extra recovery state missing");
	one_recover_a: assert property ((!fin && !rdy && ext) ##1 rdy
		|=> done || !as_n)
		else $error("recovery longer than one state");
	idle_quiet_a: assert property (req_ready |-> as_n && fin)
		else $error("bus active while idle");
	start_strobe_a: assert property (req_valid && req_ready && ext
		|-> ##[1:3] !as_n)
		else $error("request taken but no address state");
endmodule

// ===== lbs_slave_model.sv
module lbs_slave_model
	import lbs_pkg::*;
(
	// Clock and reset
	input wire logic       clock,
	input wire logic       rst,
	// Wait states to insert
	input wire logic [7:0] wait_a,
	input wire logic [7:0] wait_d,
	input wire logic [7:0] wait_r,
	// Bus
	input wire lbs_bus_t   local_bus,
	output logic [31:0]    ad_in,
	output logic           external_ready_recover_n
);
	int unsigned beats_q[$];
	logic [3:0]  fbe_q[$];
	logic [3:0]  lbe_q[$];
	logic [31:0] addr_q[$];
	logic [31:0] wd_q[$];
	logic [31:0] rd_q[$];
	logic [1:0]  st;
	logic [7:0]  cnt;
	int unsigned nb;
	logic [3:0]  fbe;

	// Piece log plus ready driven just after each edge
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			st <= 2'h0;
			external_ready_recover_n <= 1'b1;
			ad_in <= 32'h5a5a_a5a5;
		end else begin
			ad_in <= ~ad_in; // Never a stale value on the bus
			case (st)
			2'h0: if (!local_bus.address_strobe_n) begin
				addr_q.push_back(local_bus.ad); // Length code unused
				nb = 0;
				st <= 2'h1;
				cnt <= wait_a;
				external_ready_recover_n <= (wait_a != 8'h0);
			end
			2'h1: if (!external_ready_recover_n) begin
				if (nb == 0) fbe = local_bus.byte_lane_enable_n;
				nb++;
				// Bus data and the word offered back, per transfer
				wd_q.push_back(local_bus.ad);
				rd_q.push_back(ad_in);
				if (!local_bus.final_transfer_n) begin
					beats_q.push_back(nb);
					fbe_q.push_back(fbe);
					lbe_q.push_back(local_bus.byte_lane_enable_n);
					st <= 2'h2;
					cnt <= wait_r;
					external_ready_recover_n <= (wait_r == 8'h0);
				end else begin
					cnt <= wait_d;
					external_ready_recover_n <= (wait_d != 8'h0);
				end
			end else begin
				cnt <= cnt - 8'h1;
				external_ready_recover_n <= (cnt > 8'h1);
			end
			default: if (!external_ready_recover_n) begin
				cnt <= cnt - 8'h1;
				external_ready_recover_n <= !(cnt > 8'h1);
			end else begin
				st <= 2'h0;
			end
			endcase
		end
	end
endmodule

// ===== lbs_tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lbs_pkg::*;

	logic        clock = 1'b0;
	logic        rst = 1'b1;
	lbs_req_t    req = REQ_RESET;
	logic        req_valid = 1'b0;
	logic        req_ready;
	logic        done;
	lbs_bus_t    local_bus;
	logic [31:0] ad_in;
	logic        rdy_n;
	logic [7:0]  wt_a = 8'h0;
	logic [7:0]  wt_d = 8'h0;
	logic [7:0]  wt_r = 8'h0;
	logic        user_we = 1'b0;
	logic [3:0]  user_be = 4'h0;
	logic [9:0]  user_addr = 10'h000;
	logic [31:0] user_wdata = 32'h0000_0000;
	logic [31:0] user_rdata;
	int          err_total = 0;
	int          num_checks = 0;

	always #50 clock = ~clock;

	// Staging port loads write data and shows merged read data
	lbs_sequencer #(.MEM_WORDS(1024), .INT_WAIT(0)) i_dut (
		.clock(clock), .rst(rst), .req(req), .req_valid(req_valid),
		.req_ready(req_ready), .done(done), .user_we(user_we),
		.user_be(user_be), .user_addr(user_addr), .user_wdata(user_wdata),
		.user_rdata(user_rdata), .local_bus(local_bus), .ad_in(ad_in),
		.external_ready_recover_n(rdy_n));

	lbs_slave_model i_slave (.clock(clock), .rst(rst), .wait_a(wt_a),
		.wait_d(wt_d), .wait_r(wt_r), .local_bus(local_bus),
		.ad_in(ad_in), .external_ready_recover_n(rdy_n));

	task automatic close_out();
		if (err_total == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h want %h", $time, what,
				got, exp);
		end
	endtask

	// One request; cyc counts edges from taking to done
	task automatic run(input logic w, input logic d, input logic [1:0] wc,
		input logic in, input logic [31:0] a, input logic [11:0] n,
		output int cyc);
		int t;
		i_slave.beats_q.delete();
		i_slave.fbe_q.delete();
		i_slave.lbe_q.delete();
		i_slave.addr_q.delete();
		i_slave.wd_q.delete();
		i_slave.rd_q.delete();
		req = '{write: w, dma: d, width: wc, internal: in, addr: a, nbytes: n};
		req_valid = 1'b1;
		t = 0;
		while (req_ready !== 1'b1 && t < 50) begin
			@(posedge clock);
			#1;
			t++;
		end
		@(posedge clock);
		#1;
		req_valid = 1'b0;
		cyc = 0;
		while (done !== 1'b1 && cyc < 500) begin
			@(posedge clock);
			#1;
			cyc++;
		end
		chk(done, 32'h1, "request completion");
	endtask

	// Core read; compares transfers per bus piece
	task automatic piece(input logic [1:0] wc, input logic [31:0] a,
		input logic [11:0] n, input int exp[$]);
		int c;
		run(1'b0, 1'b0, wc, 1'b0, a, n, c);
		chk(i_slave.beats_q.size(), exp.size(), "piece count");
		foreach (exp[i])
			chk(i_slave.beats_q[i], exp[i], "transfers in piece");
	endtask

	task automatic t_short();
		piece(WIDTH_8, 32'h500, 12'h2, '{2});
		piece(WIDTH_16, 32'h500, 12'h2, '{1});
		piece(WIDTH_32, 32'h500, 12'h2, '{1});
		for (int i = 0; i < 3; i++)
			piece(2'(i), 32'h501, 12'h2, '{1, 1});
	endtask

	task automatic t_word8();
		piece(WIDTH_8, 32'h200, 12'h8, '{4, 4});
		piece(WIDTH_8, 32'h201, 12'h8, '{1, 2, 4, 1});
		piece(WIDTH_8, 32'h202, 12'h8, '{2, 4, 2});
		piece(WIDTH_8, 32'h203, 12'h8, '{1, 4, 2, 1});
	endtask

	task automatic t_word16();
		piece(WIDTH_16, 32'h300, 12'h4, '{2});
		piece(WIDTH_16, 32'h308, 12'h8, '{4});
		piece(WIDTH_16, 32'h310, 12'hc, '{4, 2});
		piece(WIDTH_16, 32'h320, 12'h10, '{4, 4});
		piece(WIDTH_16, 32'h301, 12'h4, '{1, 1, 1});
		piece(WIDTH_16, 32'h302, 12'h8, '{1, 2, 1});
		piece(WIDTH_16, 32'h303, 12'h8, '{1, 2, 1, 1});
		piece(WIDTH_16, 32'h304, 12'h8, '{2, 2});
	endtask

	task automatic t_word32();
		piece(WIDTH_32, 32'h410, 12'hc, '{3});
		chk(i_slave.fbe_q[0] | i_slave.lbe_q[0], BE_ALL, "burst lanes");
		piece(WIDTH_32, 32'h401, 12'h8, '{1, 1, 1, 1});
		piece(WIDTH_32, 32'h402, 12'h4, '{1, 1});
		piece(WIDTH_32, 32'h403, 12'h8, '{1, 1, 1, 1});
		piece(WIDTH_32, 32'h404, 12'h8, '{1, 1});
		piece(WIDTH_32, 32'h418, 12'h10, '{1, 1, 1, 1});
		piece(WIDTH_32, 32'h41c, 12'hc, '{1, 1, 1});
	endtask

	// Unaligned block move crossing a 2K boundary
	task automatic t_dma();
		int c;
		run(1'b1, 1'b1, WIDTH_32, 1'b0, 32'h7f5, 12'h10, c);
		chk(i_slave.beats_q.size(), 2, "mover pieces");
		chk(i_slave.beats_q[0], 3, "transfers to boundary");
		chk({i_slave.addr_q[1][31:2], 2'h0}, 32'h800, "second piece");
		chk(i_slave.fbe_q[0], 4'h1, "first lanes");
		chk(i_slave.lbe_q[1], 4'he, "last lanes");
	endtask

	// Staged word goes out on a core write; a core read lands in memory
	task automatic t_stage();
		int c;
		user_be = 4'hf;
		user_wdata = 32'hc3a5_9601;
		user_we = 1'b1;
		@(posedge clock);
		#1;
		user_we = 1'b0;
		run(1'b1, 1'b0, WIDTH_32, 1'b0, 32'h100, 12'h4, c);
		chk(i_slave.wd_q[0], 32'hc3a5_9601, "write data");
		chk(local_bus.write, 32'h1, "write direction");
		run(1'b0, 1'b0, WIDTH_32, 1'b0, 32'h100, 12'h4, c);
		chk(local_bus.write, 32'h0, "read direction");
		chk(user_rdata, i_slave.rd_q[0], "read data merged");
	endtask

	// Same transfer with and without waits: 2+3*1 data, 2 recovery
	task automatic t_waits();
		int c0;
		int c1;
		for (int w = 0; w < 2; w++) begin
			wt_a = 8'h0;
			wt_d = 8'h0;
			wt_r = 8'h0;
			run(w[0], 1'b0, WIDTH_32, 1'b0, 32'h600, 12'h10, c0);
			wt_a = 8'h2;
			wt_d = 8'h1;
			wt_r = 8'h2;
			run(w[0], 1'b0, WIDTH_32, 1'b0, 32'h600, 12'h10, c1);
			chk(c1 - c0, 7, "wait cycles");
		end
	endtask

	// Internal region ignores a ready line that never comes
	task automatic t_internal();
		int c0;
		int c1;
		wt_a = 8'h0;
		wt_r = 8'h0;
		run(1'b0, 1'b0, WIDTH_32, 1'b0, 32'h700, 12'h4, c0);
		wt_a = 8'hc8;
		run(1'b0, 1'b0, WIDTH_32, 1'b1, 32'h700, 12'h4, c1);
		chk(c1, c0, "internal timing");
	endtask

	initial begin
		#2000000;
		err_total++;
		close_out();
	end

	initial begin
		repeat (2) @(posedge clock);
		#1;
		rst = 1'b0;
		t_short();
		t_word8();
		t_word16();
		t_word32();
		t_dma();
		t_stage();
		t_waits();
		t_internal();
		close_out();
	end
endmodule

bind lbs_sequencer lbs_monitor i_mon (.clock(clock), .rst(rst),
	.req(req), .req_valid(req_valid), .req_ready(req_ready),
	.done(done), .local_bus(local_bus),
	.external_ready_recover_n(external_ready_recover_n));
